// ==== fso_consts.svh ====
// constants of the suspend, one-time-program and sector protection command sequencer
`ifndef FSO_CONSTS_SVH
`define FSO_CONSTS_SVH

`define FSO_OP_WRITE_ENABLE_CMD        8'h06
`define FSO_OP_OTP_PROG    8'h42
`define FSO_OP_OTP_READ    8'h4b
`define FSO_OP_SPR_READ    8'h2b
`define FSO_OP_SPR_PROG    8'h2f
`define FSO_OP_RESUME_A    8'h7a
`define FSO_OP_RESUME_B    8'h8a
`define FSO_OP_RESUME_C    8'h30
`define FSO_OP_SOFT_RESET  8'hf0
`define FSO_OP_MODE_RESET  8'hff

`define FSO_OTP_AW         10
`define FSO_OTP_LAST       10'h3ff
`define FSO_SPR_BITS       6'h10
`define FSO_SPR_RESET      16'hffff
`define FSO_PIN_RESET      6'h20

`define FSO_CLK_PERIOD_NS  8
`define FSO_PROG_TIME_NS   2000
`define FSO_PROG_CYC       ((`FSO_PROG_TIME_NS + `FSO_CLK_PERIOD_NS - 1) / `FSO_CLK_PERIOD_NS)

`endif

// ==== fso_pkg.sv ====
// types shared by the command sequencer files
package fso_pkg;

    typedef enum logic [2:0] {
        ST_CMD,
        ST_ADDR,
        ST_DUMMY,
        ST_RDATA,
        ST_WDATA,
        ST_IGNORE
    } fso_state_t;

    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic [3:0] io;
    } fso_pin_t;

    typedef struct packed {
        logic write_in_progress;
        logic write_enable_latch;
        logic p_err;
    } fso_status_t;

endpackage

// ==== fso_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none

module fso_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RST;
            q    <= RST;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

`default_nettype wire

// ==== fso_otp_mem.sv ====
// one-time-program array: program clears bits only, registered read
`timescale 1ns/1ns
`default_nettype none
`include "fso_consts.svh"

module fso_otp_mem (
    // clock
    input  wire logic                      clk,
    // program port
    input  wire logic                      we,
    input  wire logic [`FSO_OTP_AW-1:0]    waddr,
    input  wire logic [7:0]                wdata,
    // read port
    input  wire logic [`FSO_OTP_AW-1:0]    raddr,
    output logic      [7:0]                rdata
);

    logic [7:0] mem [0:(1<<`FSO_OTP_AW)-1];

    // erased array reads as all ones
    initial begin
        for (int i = 0; i < (1 << `FSO_OTP_AW); i++) begin
            mem[i] = 8'hff;
        end
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= mem[waddr] & wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

`default_nettype wire

// ==== fso_seq.sv ====
// serial flash sequencer: suspend filtering, resume, one-time array and protection register
`timescale 1ns/1ns
`default_nettype none
`include "fso_consts.svh"

module fso_seq (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // serial link pins
    input  wire logic                  cs_n,
    input  wire logic                  sck,
    input  wire logic [3:0]            io_in,
    output logic      [3:0]            io_out,
    output logic      [3:0]            io_oe_n,
    // configuration
    input  wire logic                  quad_all_mode,
    input  wire logic [3:0]            volatile_config_reg2_lat,
    input  wire logic                  addr_len32,
    input  wire logic                  otp_locked,
    // array engine
    input  wire logic                  erase_suspended,
    input  wire logic                  program_suspended,
    input  wire logic                  array_busy,
    output logic                       resume_program,
    output logic                       resume_erase,
    output logic [7:0]                 fwd_cmd,
    output logic                       fwd_valid,
    output logic                       soft_reset,
    // status
    output fso_pkg::fso_status_t       status,
    output logic [15:0]                sector_prot_reg
);

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    // whether an instruction may run in the present suspend state
    function automatic logic cmd_allowed(input logic [7:0] op, input logic es,
                                         input logic ps);
        logic ok;
        ok = 1'b0;
        if (!(es || ps)) begin
            ok = 1'b1;
        end else begin
            case (op)
                8'heb, 8'hec, 8'hed, 8'hee: ok = 1'b1;
                `FSO_OP_SOFT_RESET, `FSO_OP_MODE_RESET: ok = 1'b1;
                `FSO_OP_RESUME_A, `FSO_OP_RESUME_B, `FSO_OP_RESUME_C: ok = 1'b1;
                8'h13, 8'h0b, 8'h0c, 8'hbb, 8'hbc, 8'h66, 8'h99: ok = 1'b1;
                8'he0, 8'he1, 8'he2, 8'hfa, 8'hfb, 8'hfc, 8'h82: ok = es;
                default: ok = 1'b0;
            endcase
        end
        return ok;
    endfunction

    function automatic logic [31:0] shift_in(input logic [31:0] s, input logic [3:0] d,
                                             input logic quad);
        logic [31:0] r;
        r = quad ? {s[27:0], d} : {s[30:0], d[0]};
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // reset release and pin sampling

    logic             rst_meta;
    logic             rst_sync_n;
    fso_pkg::fso_pin_t pin_raw;
    fso_pkg::fso_pin_t pin_s;
    logic             sck_d;
    logic             cs_d;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    assign pin_raw = {cs_n, sck, io_in};

    fso_sync #(
        .W   (6),
        .RST (`FSO_PIN_RESET)
    ) u_pin_sync (
        .clk   (ref_clk),
        .rst_n (rst_sync_n),
        .d     (pin_raw),
        .q     (pin_s)
    );

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sck_d <= 1'b0;
            cs_d  <= 1'b1;
        end else begin
            sck_d <= pin_s.sck;
            cs_d  <= pin_s.cs_n;
        end
    end

    logic       frame;
    logic       sck_rise;
    logic       sck_fall;
    logic       cs_rise;
    logic [5:0] step;

    assign frame    = ~pin_s.cs_n;
    assign sck_rise = frame & pin_s.sck & ~sck_d;
    assign sck_fall = frame & ~pin_s.sck & sck_d;
    assign cs_rise  = pin_s.cs_n & ~cs_d;
    assign step     = quad_all_mode ? 6'h04 : 6'h01;

    ////////////////////////////////////////////////////////////////////////////////
    // command state machine

    fso_pkg::fso_state_t state;
    logic [7:0]          cmd;
    logic [31:0]         sh;
    logic [5:0]          bcnt;
    logic [3:0]          dcnt;
    logic [31:0]         next_sh;
    logic [5:0]          next_bcnt;
    logic [5:0]          alen;
    logic                dec_valid;
    logic [7:0]          dec_code;
    logic                own_busy;
    logic [`FSO_OTP_AW-1:0] waddr;
    logic                wbyte_done;

    assign next_sh    = shift_in(sh, pin_s.io, quad_all_mode);
    assign next_bcnt  = bcnt + step;
    assign alen       = addr_len32 ? 6'h20 : 6'h18;
    assign wbyte_done = sck_rise && state == fso_pkg::ST_WDATA
                        && cmd == `FSO_OP_OTP_PROG && next_bcnt[2:0] == 3'h0;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state     <= fso_pkg::ST_CMD;
            cmd       <= 8'h00;
            sh        <= 32'h0000_0000;
            bcnt      <= 6'h00;
            dcnt      <= 4'h0;
            dec_valid <= 1'b0;
            dec_code  <= 8'h00;
        end else begin
            dec_valid <= 1'b0;
            if (!frame) begin
                state <= fso_pkg::ST_CMD;
                bcnt  <= 6'h00;
                sh    <= 32'h0000_0000;
            end else if (sck_rise) begin
                case (state)
                    fso_pkg::ST_CMD: begin
                        sh   <= next_sh;
                        bcnt <= next_bcnt;
                        if (next_bcnt == 6'h08) begin
                            cmd       <= next_sh[7:0];
                            sh        <= 32'h0000_0000;
                            bcnt      <= 6'h00;
                            dcnt      <= 4'h0;
                            dec_valid <= cmd_allowed(next_sh[7:0], erase_suspended,
                                                     program_suspended);
                            dec_code  <= next_sh[7:0];
                            state     <= fso_pkg::ST_IGNORE;
                            if (cmd_allowed(next_sh[7:0], erase_suspended, program_suspended)) begin
                                case (next_sh[7:0])
                                    `FSO_OP_OTP_PROG: begin
                                        if (status.write_enable_latch && !own_busy) begin
                                            state <= fso_pkg::ST_ADDR;
                                        end
                                    end
                                    `FSO_OP_OTP_READ: state <= fso_pkg::ST_ADDR;
                                    `FSO_OP_SPR_READ: state <= fso_pkg::ST_RDATA;
                                    `FSO_OP_SPR_PROG: begin
                                        if (status.write_enable_latch && !own_busy) begin
                                            state <= fso_pkg::ST_WDATA;
                                        end
                                    end
                                    default: state <= fso_pkg::ST_IGNORE;
                                endcase
                            end
                        end
                    end
                    fso_pkg::ST_ADDR: begin
                        sh   <= next_sh;
                        bcnt <= next_bcnt;
                        if (next_bcnt == alen) begin
                            bcnt <= 6'h00;
                            if (next_sh[31:`FSO_OTP_AW] != 22'h00_0000) begin
                                state <= fso_pkg::ST_IGNORE;
                            end else if (cmd == `FSO_OP_OTP_PROG) begin
                                state <= fso_pkg::ST_WDATA;
                            end else if (volatile_config_reg2_lat != 4'h0) begin
                                state <= fso_pkg::ST_DUMMY;
                            end else begin
                                state <= fso_pkg::ST_RDATA;
                            end
                        end
                    end
                    fso_pkg::ST_DUMMY: begin
                        dcnt <= dcnt + 4'h1;
                        if (dcnt + 4'h1 == volatile_config_reg2_lat) begin
                            state <= fso_pkg::ST_RDATA;
                        end
                    end
                    fso_pkg::ST_WDATA: begin
                        sh <= next_sh;
                        if (cmd == `FSO_OP_OTP_PROG || bcnt < 6'h20) begin
                            bcnt <= next_bcnt;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one-time-program array access

    logic [`FSO_OTP_AW-1:0] raddr;
    logic                   rd_beyond;
    logic [7:0]             mem_rdata;
    logic                   mem_we;
    logic                   lock_fail;
    logic                   otp_touched;
    logic                   load_word;

    assign lock_fail = wbyte_done && otp_locked && next_sh[7:0] != 8'hff;
    assign mem_we    = wbyte_done && !otp_locked;

    fso_otp_mem u_otp_mem (
        .clk   (ref_clk),
        .we    (mem_we),
        .waddr (waddr),
        .wdata (next_sh[7:0]),
        .raddr (raddr),
        .rdata (mem_rdata)
    );

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            waddr       <= '0;
            raddr       <= '0;
            rd_beyond   <= 1'b0;
            otp_touched <= 1'b0;
        end else begin
            if (sck_rise && state == fso_pkg::ST_ADDR && next_bcnt == alen) begin
                waddr       <= next_sh[`FSO_OTP_AW-1:0];
                raddr       <= next_sh[`FSO_OTP_AW-1:0];
                rd_beyond   <= 1'b0;
                otp_touched <= 1'b0;
            end else if (wbyte_done) begin
                waddr       <= waddr + 10'h001;
                otp_touched <= 1'b1;
            end else if (load_word && cmd == `FSO_OP_OTP_READ) begin
                if (raddr == `FSO_OTP_LAST) begin
                    rd_beyond <= 1'b1;
                end
                raddr <= raddr + 10'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data output on falling clock edges

    logic [15:0] out_sh;
    logic [5:0]  ocnt;
    logic [15:0] word;
    logic [5:0]  olen;
    logic [5:0]  next_ocnt;

    assign load_word = sck_fall && state == fso_pkg::ST_RDATA && ocnt == 6'h00;
    assign olen      = (cmd == `FSO_OP_SPR_READ) ? `FSO_SPR_BITS : 6'h08;
    assign next_ocnt = ocnt + step;

    always_comb begin
        word = out_sh;
        if (ocnt == 6'h00) begin
            if (cmd == `FSO_OP_SPR_READ) begin
                word = {sector_prot_reg[7:0], sector_prot_reg[15:8]};
            end else begin
                word = {(rd_beyond ? 8'hff : mem_rdata), 8'h00};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            out_sh  <= 16'h0000;
            ocnt    <= 6'h00;
            io_out  <= 4'h0;
            io_oe_n <= 4'hf;
        end else if (!frame || state != fso_pkg::ST_RDATA) begin
            ocnt    <= 6'h00;
            io_oe_n <= 4'hf;
        end else if (sck_fall) begin
            if (quad_all_mode) begin
                io_out  <= word[15:12];
                io_oe_n <= 4'h0;
                out_sh  <= {word[11:0], 4'h0};
            end else begin
                io_out  <= {2'b00, word[15], 1'b0};
                io_oe_n <= 4'hd;
                out_sh  <= {word[14:0], 1'b0};
            end
            ocnt <= (next_ocnt == olen) ? 6'h00 : next_ocnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // self-timed program and protection register

    logic [11:0] busy_cnt;
    logic        start_prog;
    logic        prog_done;
    logic        start_spr;

    assign own_busy   = busy_cnt != 12'h000;
    assign start_spr  = cs_rise && state == fso_pkg::ST_WDATA && cmd == `FSO_OP_SPR_PROG
                        && bcnt == `FSO_SPR_BITS;
    assign start_prog = start_spr || (cs_rise && state == fso_pkg::ST_WDATA
                        && cmd == `FSO_OP_OTP_PROG && otp_touched);
    assign prog_done  = busy_cnt == 12'h001;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            busy_cnt        <= 12'h000;
            sector_prot_reg <= `FSO_SPR_RESET;
        end else begin
            if (soft_reset) begin
                busy_cnt <= 12'h000;
            end else if (start_prog) begin
                busy_cnt <= 12'(`FSO_PROG_CYC);
            end else if (own_busy) begin
                busy_cnt <= busy_cnt - 12'h001;
            end
            if (start_spr) begin
                sector_prot_reg <= sector_prot_reg & {sh[7:0], sh[15:8]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command side effects and forwarding

    logic is_resume;
    logic resume_hold;

    assign is_resume = dec_code == `FSO_OP_RESUME_A || dec_code == `FSO_OP_RESUME_B
                       || dec_code == `FSO_OP_RESUME_C;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            resume_program <= 1'b0;
            resume_erase   <= 1'b0;
            resume_hold    <= 1'b0;
            soft_reset     <= 1'b0;
            fwd_cmd        <= 8'h00;
            fwd_valid      <= 1'b0;
        end else begin
            resume_program <= 1'b0;
            resume_erase   <= 1'b0;
            soft_reset     <= 1'b0;
            fwd_valid      <= 1'b0;
            if (dec_valid && is_resume) begin
                resume_program <= program_suspended;
                resume_erase   <= erase_suspended && !program_suspended;
            end else if (dec_valid && dec_code == `FSO_OP_SOFT_RESET) begin
                soft_reset <= 1'b1;
            end else if (dec_valid && dec_code != `FSO_OP_WRITE_ENABLE_CMD
                         && dec_code != `FSO_OP_OTP_PROG && dec_code != `FSO_OP_OTP_READ
                         && dec_code != `FSO_OP_SPR_READ && dec_code != `FSO_OP_SPR_PROG) begin
                fwd_cmd   <= dec_code;
                fwd_valid <= 1'b1;
            end
            // hold progress until the engine picks the resumed work up
            if (dec_valid && is_resume && (program_suspended || erase_suspended)) begin
                resume_hold <= 1'b1;
            end else if (array_busy || soft_reset) begin
                resume_hold <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status flags

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            status <= '0;
        end else begin
            status.write_in_progress <= own_busy || start_prog || array_busy || resume_hold
                          || (dec_valid && is_resume && (program_suspended || erase_suspended));
            if (dec_valid && dec_code == `FSO_OP_WRITE_ENABLE_CMD) begin
                status.write_enable_latch <= 1'b1;
            end else if (prog_done || soft_reset) begin
                status.write_enable_latch <= 1'b0;
            end
            if (lock_fail) begin
                status.p_err <= 1'b1;
            end else if (soft_reset) begin
                status.p_err <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// ==== fso_seq_asserts.sv ====
// concurrent checks on the sequencer ports
`timescale 1ns/1ns
`default_nettype none
module fso_seq_chk (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // link and inputs
    input  wire logic                 cs_n,
    input  wire logic [3:0]           io_oe_n,
    input  wire logic                 otp_locked,
    input  wire logic                 program_suspended,
    input  wire logic                 erase_suspended,
    // outputs
    input  wire logic                 resume_program,
    input  wire logic                 resume_erase,
    input  wire logic [7:0]           fwd_cmd,
    input  wire logic                 fwd_valid,
    input  wire logic                 soft_reset,
    input  wire fso_pkg::fso_status_t status,
    input  wire logic [15:0]          sector_prot_reg
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_resume;
        resume_program || resume_erase;
    endsequence
    sequence s_wip_soon;
        ##[0:2] status.write_in_progress;
    endsequence
    a_idle_oe: assert property (cs_n [*6] |-> io_oe_n == 4'hf)
        else $error("outputs enabled while deselected");
    a_resume_prog: assert property (resume_program |-> program_suspended)
        else $error("program resume without suspended program");
    a_resume_erase: assert property (resume_erase |-> erase_suspended && !program_suspended)
        else $error("erase resume with wrong suspend state");
    a_resume_wip: assert property (s_resume |-> s_wip_soon)
        else $error("progress flag not set by resume");
    a_erase_only: assert property (fwd_valid && fwd_cmd inside {8'he0, 8'he1, 8'he2}
        |-> !program_suspended)
        else $error("erase suspend command passed in program suspend");
    a_fwd_pulse: assert property (fwd_valid |=> !fwd_valid)
        else $error("forward strobe longer than one cycle");
    a_wip_hold: assert property ($rose(status.write_in_progress) |-> status.write_in_progress [*8])
        else $error("progress flag dropped early");
    a_err_locked: assert property ($rose(status.p_err) |-> otp_locked)
        else $error("error flag without locked region");
    a_prot_cs: assert property (!$stable(sector_prot_reg) |->
        cs_n && (sector_prot_reg & ~$past(sector_prot_reg)) == 16'h0)
        else $error("protection register changed wrongly");
    a_soft_clear: assert property (soft_reset |-> ##[0:3] !status.p_err)
        else $error("error flag kept after software reset");
endmodule
bind fso_seq fso_seq_chk fso_seq_chk_inst (.ref_clk, .rst_n, .cs_n, .io_oe_n, .otp_locked,
    .program_suspended, .erase_suspended, .resume_program, .resume_erase, .fwd_cmd,
    .fwd_valid, .soft_reset, .status, .sector_prot_reg);
`default_nettype wire

// ==== fso_host_model.sv ====
// host side of the serial link: frames bits on select, clock and data pins
`timescale 1ns/1ns
`default_nettype none
module fso_host_model (
    // clock
    input  wire logic       clk,
    // link
    output logic            cs_n,
    output logic            sck,
    output logic      [3:0] io_in,
    input  wire logic [3:0] io_out
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        io_in = 4'h0;
    end
    task automatic half();
        repeat (5) @(posedge clk);
    endtask
    // ntx bits out msb first (a nibble per clock in quad), then nrx bits in from io_out[1] (nrx/4 in quad)
    task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx, input logic quad,
                        output logic [31:0] rx);
        rx = 32'h0;
        cs_n <= 1'b0;
        half();
        for (int i = 0; i < ntx + nrx; i += (quad ? 4 : 1)) begin
            if (i >= ntx)
                io_in <= ~io_in;
            else if (quad)
                io_in <= tx[ntx-1-i -: 4];
            else
                io_in <= {~io_in[3:1], tx[ntx-1-i]};
            half();
            sck <= 1'b1;
            if (i >= ntx)
                rx = {rx[30:0], io_out[1]};
            half();
            sck <= 1'b0;
        end
        half();
        cs_n <= 1'b1;
        io_in <= ~io_in;
        half();
    endtask
endmodule
`default_nettype wire

// ==== tb_fso_seq.sv ====
// testbench: drives the sequencer through the host model and checks its ports
`timescale 1ns/1ns
`default_nettype none
module tb_fso_seq;
    logic                 ref_clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 cs_n, sck, resume_program, resume_erase, fwd_valid, soft_reset;
    logic [3:0]           io_in, io_out, io_oe_n;
    logic                 quad_all_mode = 1'b0;
    logic                 otp_locked = 1'b0;
    logic                 erase_suspended = 1'b0;
    logic                 program_suspended = 1'b0;
    logic                 array_busy = 1'b0;
    logic [3:0]           lat = 4'h4;
    logic [7:0]           fwd_cmd, l0, last_cmd = 8'h00;
    logic [15:0]          sector_prot_reg;
    fso_pkg::fso_status_t status;
    logic [31:0]          rx;
    int                   mismatches = 0, total_checks = 0, n_fwd = 0, n_rp = 0, n_re = 0, n_sr = 0;
    logic [7:0]           ops[8] = '{8'he0, 8'he1, 8'he2, 8'heb, 8'hec, 8'hed, 8'hee, 8'hff};
    logic [7:0]           res[3] = '{8'h7a, 8'h8a, 8'h30};
    int                   c0;
    always #4 ref_clk = ~ref_clk;
    fso_seq fso_seq_inst (.ref_clk, .rst_n, .cs_n, .sck, .io_in, .io_out, .io_oe_n,
        .quad_all_mode, .volatile_config_reg2_lat(lat), .addr_len32(1'b0), .otp_locked,
        .erase_suspended, .program_suspended, .array_busy, .resume_program,
        .resume_erase, .fwd_cmd, .fwd_valid, .soft_reset, .status, .sector_prot_reg);
    fso_host_model fso_host_model_inst (.clk(ref_clk), .cs_n, .sck, .io_in, .io_out);
    always @(posedge ref_clk) begin
        if (fwd_valid === 1'b1) begin
            n_fwd++;
            last_cmd = fwd_cmd;
        end
        n_rp += (resume_program === 1'b1);
        n_re += (resume_erase === 1'b1);
        n_sr += (soft_reset === 1'b1);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [63:0] tx, input int n);
        fso_host_model_inst.xfer(tx, n, 0, 1'b0, rx);
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 400 && status.write_in_progress !== 1'b0; k++) @(posedge ref_clk);
    endtask
    task automatic prog(input logic [23:0] a, input logic [7:0] d, input logic [2:0] st);
        cmd(8'h06, 8);
        cmd({8'h42, a, d}, 40);
        repeat (4) @(posedge ref_clk);
        chk(status.write_in_progress, 1'b1);
        wait_idle();
        chk(status, st);
    endtask
    task automatic rd(input logic [23:0] a, input int n);
        fso_host_model_inst.xfer({8'h4b, a, 4'h0} >> (4 - lat), 32 + lat, n, 1'b0, rx);
    endtask
    task automatic susp(input logic e, input logic p);
        @(posedge ref_clk);
        erase_suspended <= e;
        program_suspended <= p;
        array_busy <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk(status.write_in_progress, 1'b1);
        array_busy <= 1'b0;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk(sector_prot_reg, 16'hffff);
        chk(status, 3'b000);
        cmd({8'h2f, 16'h00a5}, 24);
        wait_idle();
        chk(sector_prot_reg, 16'hffff);
        cmd(8'h06, 8);
        chk(status, 3'b010);
        cmd({8'h2f, 15'h0}, 23);
        chk(status, 3'b010);
        cmd({8'h2f, 8'h5a, 8'hc3}, 24);
        repeat (4) @(posedge ref_clk);
        chk(status.write_in_progress, 1'b1);
        wait_idle();
        chk(status, 3'b000);
        chk(sector_prot_reg, 16'hc35a);
        fso_host_model_inst.xfer(8'h2b, 8, 32, 1'b0, rx);
        chk(rx, 32'h5ac35ac3);
        prog(24'h000000, 8'h00, 3'b000);
        prog(24'h000010, 8'h3c, 3'b000);
        prog(24'h000010, 8'hf5, 3'b000);
        rd(24'h000010, 8);
        chk(rx, 32'h34);
        rd(24'h0003ff, 16);
        chk(rx, 32'hffff);
        cmd(8'h06, 8);
        cmd({8'h42, 24'h000410, 8'h00}, 40);
        chk(status, 3'b010);
        otp_locked <= 1'b1;
        lat <= 4'h0;
        prog(24'h000010, 8'hff, 3'b000);
        prog(24'h000010, 8'h00, 3'b001);
        rd(24'h000010, 8);
        chk(rx, 32'h34);
        for (int s = 0; s < 2; s++) begin
            susp(s[0], !s[0]);
            foreach (ops[j]) begin
                c0 = n_fwd;
                l0 = last_cmd;
                cmd(ops[j], 8);
                chk(n_fwd - c0, (s == 1 || j > 2));
                chk(last_cmd, (s == 1 || j > 2) ? ops[j] : l0);
            end
        end
        cmd(8'h06, 8);
        chk(status.write_enable_latch, 1'b0);
        quad_all_mode <= 1'b1;
        fso_host_model_inst.xfer(8'hec, 8, 0, 1'b1, rx);
        chk(last_cmd, 8'hec);
        quad_all_mode <= 1'b0;
        susp(1'b1, 1'b1);
        foreach (res[r]) begin
            c0 = n_rp;
            cmd(res[r], 8);
            chk(n_rp - c0, 1);
        end
        susp(1'b1, 1'b0);
        cmd(8'h7a, 8);
        chk({n_re[30:0], status.write_in_progress}, {31'd1, 1'b1});
        susp(1'b0, 1'b0);
        cmd(8'h8a, 8);
        chk(n_rp + n_re, 4);
        chk(status.write_in_progress, 1'b0);
        cmd(8'hf0, 8);
        repeat (4) @(posedge ref_clk);
        chk(n_sr, 1);
        chk(status, 3'b000);
        close_out();
    end
endmodule
`default_nettype wire
